// ==== inc/ppd_pkg.sv ====
// package for the six-pin port with direction, data and function mux
// assumes a 32-bit classic wishbone master and a single bus clock
package ppd_pkg;
  localparam int PPD_PINS = 6;
  localparam int PPD_NMI_PIN = 1;
  localparam int PPD_IRQ_PIN = 5;
  localparam int PPD_AW = 8;
  // register byte offsets
  localparam logic [7:0] PPD_OFS_DATA = 8'h00;
  localparam logic [7:0] PPD_OFS_LEVEL = 8'h04;
  localparam logic [7:0] PPD_OFS_DIR = 8'h08;
  localparam logic [7:0] PPD_OFS_IRQCTL = 8'h0C;
  localparam logic [7:0] PPD_OFS_POL = 8'h10;
  localparam logic [7:0] PPD_OFS_IE = 8'h14;
  localparam logic [7:0] PPD_OFS_FLAG = 8'h18;
  // irq pin control field
  localparam int PPD_IRQ_PIN_ENABLE_BIT = 0;
  localparam logic [PPD_PINS-1:0] PPD_RST_PINS = 6'h00;
  localparam logic [31:0] PPD_RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [PPD_AW-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ppd_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ppd_wb_rsp_t;

  typedef struct packed {
    logic [PPD_PINS-1:0] data;
    logic [PPD_PINS-1:0] dir;
    logic irq_pin_enable;
    logic [PPD_PINS-1:0] pol;
    logic [PPD_PINS-1:0] ie;
    logic [PPD_PINS-1:0] flag;
    logic [PPD_PINS-1:0] sync1;
    logic [PPD_PINS-1:0] sync2;
    logic [PPD_PINS-1:0] prev;
    logic nmi_armed;
    logic ack;
    logic [31:0] rdata;
    logic [PPD_PINS-1:0] pin_out;
    logic [PPD_PINS-1:0] pin_oe;
    logic nmi_level_n;
    logic irq_level_n;
  } ppd_state_t;
endpackage

// ==== src/ppd_port.sv ====
// six-pin port: data, pin level and direction registers with function mux
// assumes asynchronous pins, a classic wishbone master and pwm/cpu inputs
// Operation
// R1: once the cpu nonmaskable mask first clears, pin 1 is held as input for good.
// R2: the nonmaskable input on pin 1 is enabled only by clearing the cpu mask bit.
// R3: an enabled nonmaskable function on pin 1 beats both pwm and gpio.
// R4: an enabled pwm channel beats gpio on its pin.
// R5: with no alternate function and direction output, the data bit drives the pin.
// R6: a data read gives the stored bit when direction is 1, else the synced pin.
// R7: each pin can flag an interrupt edge whether it is input or output.
// R8: the pin level register always reads the synced pins and ignores writes.
// R9: direction 1 means output and 0 means input.
// R10: the enabled maskable interrupt forces pin 5 to input, direction bit untouched.
// R11: an enabled pwm channel forces pins 1 and 0 to output, direction bit untouched.
// R12: the direction register is readable and writable at any time.
// R13: the maskable interrupt on pin 5 is enabled when its control enable bit is 1.
// R14: polarity 1 picks a rising interrupt edge and 0 a falling one.
// R15: every pin input passes two flip-flops before reads or edge detection.
`timescale 1ns/1ps
module ppd_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input ppd_pkg::ppd_wb_req_t wb_req_i,
  output ppd_pkg::ppd_wb_rsp_t wb_rsp_o,
  // pins
  input wire logic [ppd_pkg::PPD_PINS-1:0] pin_i,
  output logic [ppd_pkg::PPD_PINS-1:0] pin_o,
  output logic [ppd_pkg::PPD_PINS-1:0] pin_oe_o,
  // alternate functions
  input wire logic cpu_xmask_i,
  input wire logic [ppd_pkg::PPD_PINS-1:0] pwm_en_i,
  input wire logic [ppd_pkg::PPD_PINS-1:0] pwm_val_i,
  output logic nonmaskable_irq_input_n_o,
  output logic irq_pin_level_n_o,
  // pin interrupt
  output logic pin_irq_o
);
  import ppd_pkg::*;

  ppd_state_t r;
  ppd_state_t r_nxt;
  logic [PPD_PINS-1:0] force_in;
  logic [PPD_PINS-1:0] oe_w;
  logic [PPD_PINS-1:0] out_w;
  logic [PPD_PINS-1:0] edge_w;
  logic [PPD_PINS-1:0] wmask;
  logic req;
  logic wr;
  logic [PPD_PINS-1:0] wd;
  logic [PPD_PINS-1:0] data_rd;
  logic dir_wr;

  assign req = wb_req_i.cyc && wb_req_i.stb;
  // write lands at the edge where ack is high
  assign wr = req && wb_req_i.we && r.ack && wb_req_i.sel[0];
  assign wd = wb_req_i.dat[PPD_PINS-1:0];
  assign data_rd = (r.dir & r.data) | (~r.dir & r.sync2); // [R6] [R9]
  assign dir_wr = wr && (wb_req_i.adr == PPD_OFS_DIR);

  // per-pin function priority
  genvar g;
  generate
    for (g = 0; g < PPD_PINS; g++) begin : g_pin
      if (g == PPD_NMI_PIN) begin : g_nmi
        assign force_in[g] = r.nmi_armed; // [R1] [R3]
      end else if (g == PPD_IRQ_PIN) begin : g_irq
        assign force_in[g] = r.irq_pin_enable; // [R10] [R13]
      end else begin : g_plain
        assign force_in[g] = 1'b0;
      end
      // forced input, then pwm, then gpio direction
      assign oe_w[g] = force_in[g] ? 1'b0 : (pwm_en_i[g] ? 1'b1 : r.dir[g]); // [R4] [R11] [R9]
      assign out_w[g] = pwm_en_i[g] ? pwm_val_i[g] : r.data[g]; // [R4] [R5]
      // active edge on synced level
      assign edge_w[g] = r.pol[g] ? (r.sync2[g] && !r.prev[g])
                                  : (!r.sync2[g] && r.prev[g]); // [R14] [R7]
      assign wmask[g] = wr && (wb_req_i.adr == PPD_OFS_FLAG) && wd[g];
    end
  endgenerate

  always_comb begin
    r_nxt = r;
    // two-stage synchroniser
    r_nxt.sync1 = pin_i; // [R15]
    r_nxt.sync2 = r.sync1; // [R15]
    r_nxt.prev = r.sync2;
    // arm on first clear of the cpu mask, never disarm
    r_nxt.nmi_armed = r.nmi_armed || !cpu_xmask_i; // [R1] [R2]
    r_nxt.pin_oe = oe_w;
    r_nxt.pin_out = out_w;
    r_nxt.nmi_level_n = r.nmi_armed ? r.sync2[PPD_NMI_PIN] : 1'b1; // [R2]
    r_nxt.irq_level_n = r.irq_pin_enable ? r.sync2[PPD_IRQ_PIN] : 1'b1; // [R13]
    // flags: set beats write-one clear
    r_nxt.flag = (r.flag & ~wmask) | edge_w; // [R7]
    // bus answer one cycle after request, one cycle wide
    r_nxt.ack = req && !r.ack;
    r_nxt.rdata = PPD_RD_ZERO;
    if (req && !r.ack) begin
      case (wb_req_i.adr)
        PPD_OFS_DATA: r_nxt.rdata[PPD_PINS-1:0] = data_rd; // [R6]
        PPD_OFS_LEVEL: r_nxt.rdata[PPD_PINS-1:0] = r.sync2; // [R8]
        PPD_OFS_DIR: r_nxt.rdata[PPD_PINS-1:0] = r.dir; // [R12]
        PPD_OFS_IRQCTL: r_nxt.rdata[PPD_IRQ_PIN_ENABLE_BIT] = r.irq_pin_enable;
        PPD_OFS_POL: r_nxt.rdata[PPD_PINS-1:0] = r.pol;
        PPD_OFS_IE: r_nxt.rdata[PPD_PINS-1:0] = r.ie;
        PPD_OFS_FLAG: r_nxt.rdata[PPD_PINS-1:0] = r.flag;
        default: r_nxt.rdata = PPD_RD_ZERO;
      endcase
    end
    if (wr) begin
      case (wb_req_i.adr)
        PPD_OFS_DATA: r_nxt.data = wd;
        PPD_OFS_DIR: r_nxt.dir = wd; // [R12]
        PPD_OFS_IRQCTL: r_nxt.irq_pin_enable = wb_req_i.dat[PPD_IRQ_PIN_ENABLE_BIT]; // [R13]
        PPD_OFS_POL: r_nxt.pol = wd;
        PPD_OFS_IE: r_nxt.ie = wd;
        default: r_nxt.rdata = r_nxt.rdata; // level register ignores writes [R8]
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.nmi_level_n <= 1'b1;
      r.irq_level_n <= 1'b1;
      r.data <= PPD_RST_PINS;
      r.dir <= PPD_RST_PINS;
    end else begin
      r <= r_nxt;
    end
  end

  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.rdata;
  assign pin_o = r.pin_out;
  assign pin_oe_o = r.pin_oe;
  assign nonmaskable_irq_input_n_o = r.nmi_level_n;
  assign irq_pin_level_n_o = r.irq_level_n;
  assign pin_irq_o = |(r.flag & r.ie);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_level;
    req && !r.ack && !wb_req_i.we && (wb_req_i.adr == PPD_OFS_LEVEL);
  endsequence

  sequence s_rise0;
    r.pol[0] && r.sync2[0] && !r.prev[0];
  endsequence

  chk_ack_timing: assert property ((req && !r.ack) |=> r.ack ##1 !r.ack)
    else $error("ack not a one-cycle answer");
  chk_nmi_sticky: assert property (r.nmi_armed |=> r.nmi_armed && !pin_oe_o[PPD_NMI_PIN]) // [R1]
    else $error("nmi pin not held as input");
  chk_nmi_arm_only: assert property ((!r.nmi_armed && cpu_xmask_i) |=> !r.nmi_armed) // [R2]
    else $error("nmi armed without mask clear");
  chk_nmi_over_pwm: assert property ((r.nmi_armed && pwm_en_i[PPD_NMI_PIN])
    |=> !pin_oe_o[PPD_NMI_PIN]) // [R3]
    else $error("pwm overrode nmi pin");
  chk_irq_force_in: assert property ((r.irq_pin_enable && r.dir[PPD_IRQ_PIN] && !dir_wr)
    |=> !pin_oe_o[PPD_IRQ_PIN] && r.dir[PPD_IRQ_PIN] == $past(r.dir[PPD_IRQ_PIN])) // [R10]
    else $error("irq pin not forced input");
  chk_pwm_drive: assert property ((pwm_en_i[0] && !r.dir[0])
    |=> pin_oe_o[0] && pin_o[0] == $past(pwm_val_i[0])) // [R11]
    else $error("pwm did not drive pin 0");
  chk_gpio_drive: assert property ((!pwm_en_i[2] && r.dir[2])
    |=> pin_oe_o[2] && pin_o[2] == $past(r.data[2])) // [R5]
    else $error("gpio data not driven");
  chk_level_read: assert property (s_read_level
    |=> wb_rsp_o.ack && wb_rsp_o.dat[PPD_PINS-1:0] == $past(r.sync2)) // [R8]
    else $error("level read wrong");
  chk_flag_rise: assert property (s_rise0 |=> r.flag[0]) // [R14]
    else $error("rising edge not flagged");
  chk_sync_depth: assert property (1 |-> ##2 r.sync2 == $past(pin_i, 2)) // [R15]
    else $error("synchroniser depth wrong");

  sequence s_read_at(logic [PPD_AW-1:0] a);
    req && !r.ack && !wb_req_i.we && (wb_req_i.adr == a);
  endsequence

  sequence s_fall0;
    !r.pol[0] && !r.sync2[0] && r.prev[0];
  endsequence

  chk_ack_low_idle: assert property (!req |=> !wb_rsp_o.ack)
    else $error("ack without request");

  chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");

  chk_ack_only_req: assert property (wb_rsp_o.ack |-> $past(req))
    else $error("ack not preceded by request");

  chk_rdata_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == PPD_RD_ZERO)
    else $error("read data not zero outside ack");

  chk_dir_read: assert property (s_read_at(PPD_OFS_DIR)
    |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'($past(r.dir))) // [R12]
    else $error("direction read wrong");

  chk_data_read: assert property (s_read_at(PPD_OFS_DATA)
    |=> wb_rsp_o.dat == 32'($past((r.dir & r.data) | (~r.dir & r.sync2)))) // [R6]
    else $error("data read wrong");

  chk_level_width: assert property (s_read_level
    |=> wb_rsp_o.dat == 32'($past(r.sync2))) // [R8]
    else $error("level read has stray bits");

  chk_irqctl_read: assert property (s_read_at(PPD_OFS_IRQCTL)
    |=> wb_rsp_o.dat == 32'($past(r.irq_pin_enable))) // [R13]
    else $error("irq control read wrong");

  chk_dir_write: assert property (dir_wr
    |=> r.dir == $past(wd)) // [R12]
    else $error("direction write lost");

  chk_data_write: assert property ((wr && wb_req_i.adr == PPD_OFS_DATA)
    |=> r.data == $past(wd)) // [R5]
    else $error("data write lost");

  chk_pol_write: assert property ((wr && wb_req_i.adr == PPD_OFS_POL)
    |=> r.pol == $past(wd)) // [R14]
    else $error("polarity write lost");

  chk_ie_write: assert property ((wr && wb_req_i.adr == PPD_OFS_IE)
    |=> r.ie == $past(wd)) // [R7]
    else $error("enable write lost");

  chk_irq_pin_enable_write: assert property ((wr && wb_req_i.adr == PPD_OFS_IRQCTL)
    |=> r.irq_pin_enable == $past(wb_req_i.dat[PPD_IRQ_PIN_ENABLE_BIT])) // [R13]
    else $error("irq enable write lost");

  chk_flag_fall: assert property (s_fall0 |=> r.flag[0]) // [R14]
    else $error("falling edge not flagged");

  chk_flag_hold: assert property ((r.flag[0] && !wmask[0]) |=> r.flag[0]) // [R7]
    else $error("flag lost without clear");

  chk_flag_clear: assert property ((wmask[0] && !edge_w[0]) |=> !r.flag[0]) // [R7]
    else $error("flag not cleared");

  chk_flag_set_wins: assert property ((wmask[0] && edge_w[0]) |=> r.flag[0]) // [R7]
    else $error("clear beat a new edge");

  chk_irq_line: assert property ((r.flag[3] && r.ie[3]) |-> pin_irq_o) // [R7]
    else $error("enabled flag gave no interrupt");

  chk_irq_quiet: assert property ((r.ie == '0) |-> !pin_irq_o) // [R7]
    else $error("interrupt while all masked");

  chk_sync_first: assert property (1 |=> r.sync1 == $past(pin_i)) // [R15]
    else $error("first sync stage wrong");

  chk_prev_track: assert property (1 |=> r.prev == $past(r.sync2)) // [R7]
    else $error("edge history wrong");

  chk_nmi_level_off: assert property (!r.nmi_armed
    |=> nonmaskable_irq_input_n_o) // [R2]
    else $error("nmi level active before arming");

  chk_nmi_level_on: assert property (r.nmi_armed
    |=> nonmaskable_irq_input_n_o == $past(r.sync2[PPD_NMI_PIN])) // [R2]
    else $error("nmi level not following pin");

  chk_irq_level_off: assert property (!r.irq_pin_enable
    |=> irq_pin_level_n_o) // [R13]
    else $error("irq level active while disabled");

  chk_irq_level_on: assert property (r.irq_pin_enable
    |=> irq_pin_level_n_o == $past(r.sync2[PPD_IRQ_PIN])) // [R13]
    else $error("irq level not following pin");

  chk_irq_over_pwm: assert property (r.irq_pin_enable
    |=> !pin_oe_o[PPD_IRQ_PIN]) // [R10]
    else $error("irq pin driven while enabled");

  chk_pwm_over_gpio: assert property (pwm_en_i[3]
    |=> pin_oe_o[3] && pin_o[3] == $past(pwm_val_i[3])) // [R4]
    else $error("pwm did not win on pin 3");

  chk_pwm_pin1: assert property ((!r.nmi_armed && pwm_en_i[PPD_NMI_PIN])
    |=> pin_oe_o[PPD_NMI_PIN] && pin_o[PPD_NMI_PIN] == $past(pwm_val_i[PPD_NMI_PIN])) // [R11]
    else $error("pwm did not drive pin 1");

  chk_pwm_dir_kept: assert property ((pwm_en_i[0] && !dir_wr)
    |=> r.dir[0] == $past(r.dir[0])) // [R11]
    else $error("pwm changed stored direction");

  chk_nmi_dir_kept: assert property ((r.nmi_armed && !dir_wr)
    |=> r.dir == $past(r.dir)) // [R1]
    else $error("nmi changed stored direction");

  chk_gpio_input: assert property ((!pwm_en_i[4] && !r.dir[4])
    |=> !pin_oe_o[4]) // [R9]
    else $error("input pin driven");

  chk_gpio_output: assert property ((!pwm_en_i[4] && r.dir[4])
    |=> pin_oe_o[4]) // [R9]
    else $error("output pin not driven");
endmodule

// ==== testbench/ppd_pin_model.sv ====
// far-side pin model: every pin reads back what drives it
// assumes pin_o and pin_oe come straight from the port
`timescale 1ns/1ps
module ppd_pin_model (
  // port side
  input wire logic [5:0] pin_o_i,
  input wire logic [5:0] pin_oe_i,
  // far side level and resolved pin
  input wire logic [5:0] ext_i,
  output logic [5:0] pin_lvl_o
);
  // driven pins show the port value, released ones the far side
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ==== testbench/port_pin_direction_data_mux_tb.sv ====
// directed bench for the six-pin port over wishbone
// assumes the pin model loops driven pins back to pin_i
`timescale 1ns/1ps
module port_pin_direction_data_mux_tb;
  import ppd_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic xm = 1;
  ppd_wb_req_t req = '0;
  ppd_wb_rsp_t rsp;
  logic [5:0] pin_i, pin_o, pin_oe;
  logic [5:0] pwm_en = 0;
  logic [5:0] pwm_val = 0;
  logic [5:0] ext = 0;
  logic nmi_n, irq_n, irq;
  logic [31:0] q;
  int n_mismatch = 0;
  int compares = 0;
  initial forever #25 clk_i = ~clk_i;
  ppd_port i_ppd_port (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .cpu_xmask_i(xm), .pwm_en_i(pwm_en),
    .pwm_val_i(pwm_val), .nonmaskable_irq_input_n_o(nmi_n), .irq_pin_level_n_o(irq_n),
    .pin_irq_o(irq));
  ppd_pin_model i_ppd_pin_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext),
    .pin_lvl_o(pin_i));
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    for (i = 0; i < 20 && rsp.ack !== 1'b1; i++) @(posedge clk_i);
    if (i == 20) begin
      n_mismatch++;
      results;
    end
    q = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    bus(1, PPD_OFS_DIR, 32'h3F);
    bus(1, PPD_OFS_DATA, 32'h2A);
    repeat (4) @(posedge clk_i);
    chk("oe", 32'h3F, 32'(pin_oe));
    chk("out", 32'h2A, 32'(pin_o));
    rd(PPD_OFS_DATA, 32'h2A, "data");
    rd(PPD_OFS_LEVEL, 32'h2A, "level");
    $display("drive test done");
    ext <= 6'h15;
    bus(1, PPD_OFS_DIR, 32'h0);
    bus(1, PPD_OFS_LEVEL, 32'h3F);
    rd(PPD_OFS_DATA, 32'h15, "data_in");
    rd(PPD_OFS_LEVEL, 32'h15, "level_ro");
    $display("input test done");
    pwm_en <= 6'h03;
    pwm_val <= 6'h01;
    bus(1, PPD_OFS_DIR, 32'h20);
    bus(1, PPD_OFS_IRQCTL, 32'h1);
    repeat (4) @(posedge clk_i);
    chk("oe_mux", 32'h03, 32'(pin_oe));
    chk("out_pwm", 32'h01, 32'(pin_o[1:0]));
    chk("irq_lvl", 32'h0, 32'(irq_n));
    rd(PPD_OFS_DIR, 32'h20, "dir");
    $display("mux test done");
    pwm_en <= 6'h00;
    ext <= 6'h14;
    bus(1, PPD_OFS_DIR, 32'h0);
    bus(1, PPD_OFS_IRQCTL, 32'h0);
    bus(1, PPD_OFS_POL, 32'h1);
    bus(1, PPD_OFS_FLAG, 32'h3F);
    bus(1, PPD_OFS_IE, 32'h1);
    chk("irq_idle", 32'h0, 32'(irq));
    ext <= 6'h15;
    repeat (4) @(posedge clk_i);
    chk("irq_rise", 32'h1, 32'(irq));
    bus(1, PPD_OFS_IE, 32'h0);
    chk("irq_mask", 32'h0, 32'(irq));
    bus(1, PPD_OFS_FLAG, 32'h1);
    bus(1, PPD_OFS_IE, 32'h1);
    bus(1, PPD_OFS_POL, 32'h0);
    ext <= 6'h14;
    repeat (4) @(posedge clk_i);
    chk("irq_fall", 32'h1, 32'(irq));
    bus(1, PPD_OFS_FLAG, 32'h1);
    chk("irq_clr", 32'h0, 32'(irq));
    $display("interrupt test done");
    pwm_en <= 6'h02;
    repeat (4) @(posedge clk_i);
    chk("nmi_off", 32'h1, 32'(nmi_n));
    xm <= 0;
    repeat (4) @(posedge clk_i);
    xm <= 1;
    repeat (4) @(posedge clk_i);
    chk("oe_nmi", 32'h0, 32'(pin_oe));
    chk("nmi_on", 32'h0, 32'(nmi_n));
    $display("nonmaskable test done");
    results;
  end
endmodule
